// ==== pag_pkg.sv ====
/*
 * Constants for the six-bit port A general-purpose I/O block.
 * Assumes a byte-wide register port and a single core clock.
 */
// Overview of operation
// - Port A has a six-bit output latch, one bit per pin.
// - Each pin has its own direction bit in port_a_direction.
// - Direction bit one puts the pin driver in high impedance.
// - Direction bit zero drives the pin with the latch bit.
// - Reading port_a_data returns pin levels; writing updates the latch.
// - Writes are read-modify-write: sample pins, modify, store into latch. Here only set and clear do so; a data write stores wrData directly.
// - Bit 4 is open drain: pulls low, releases when one is output.
// - The bit 4 pin also feeds the Timer0 external clock input.
// - Analog config bits select digital or analog use per remaining pin.
// - After reset analog-capable pins are analog and read as zero.
// - Direction bits still control drivers while a pin is analog.
// - An enabled sharing peripheral takes the pin from general I/O.

package pag_pkg;

   // -----------------------------------------------------------------
   // Widths and field positions
   // -----------------------------------------------------------------
   localparam int          PAG_PORT_W  = 6;
   localparam int          PAG_DATA_W  = 8;
   localparam int          PAG_ADDR_W  = 8;
   localparam int          PAG_OD_BIT  = 4;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0]  PAG_OFF_DATA   = 8'h00;
   localparam logic [7:0]  PAG_OFF_DIR    = 8'h01;
   localparam logic [7:0]  PAG_OFF_ANALOG = 8'h02;
   localparam logic [7:0]  PAG_OFF_SET    = 8'h03;
   localparam logic [7:0]  PAG_OFF_CLR    = 8'h04;
   localparam logic [7:0]  PAG_OFF_PERIPH = 8'h05;

   // -----------------------------------------------------------------
   // Reset values and masks
   // -----------------------------------------------------------------
   localparam logic [5:0]  PAG_DATA_RST   = 6'h00;
   localparam logic [5:0]  PAG_DIR_RST    = 6'h3F;
   localparam logic [5:0]  PAG_ANALOG_RST = 6'h2F;
   localparam logic [5:0]  PAG_ANALOG_CAP = 6'h2F;
   localparam logic [5:0]  PAG_PERIPH_RST = 6'h00;
   localparam logic [7:0]  PAG_RD_ZERO    = 8'h00;

endpackage

// ==== pag_pin_if.sv ====
/*
 * Carrier for raw pin levels and their synchronised copies.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ns

interface pag_pin_if;
   logic [5:0] pinRaw;    // Asynchronous pin levels.
   logic [5:0] pinLevel;  // Levels after two flip-flops.

   modport syncer (input pinRaw, output pinLevel);
   modport core   (output pinRaw, input pinLevel);
endinterface

// ==== pag_pin_sync.sv ====
/*
 * Two-stage synchroniser bank for the port A pin inputs.
 * Assumes pins change freely with respect to clk_sys.
 */
`timescale 1ns/1ns

module pag_pin_sync (
   input  wire logic  clk_sys,  // Core clock.
   input  wire logic  rstn,     // Asynchronous reset, active low.
   input  wire logic  ce,       // Clock enable.
   pag_pin_if.syncer  pins      // Raw in, synchronised out.
);

   logic [5:0] stage1;
   logic [5:0] stage2;

   // -----------------------------------------------------------------
   // Synchroniser stages
   // -----------------------------------------------------------------
   // The first stage is read by the second stage only, to contain
   // metastability.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stage1 <= 6'h00;
         stage2 <= 6'h00;
      end else if (ce) begin
         stage1 <= pins.pinRaw;
         stage2 <= stage1;
      end
   end

   assign pins.pinLevel = stage2;

endmodule // pag_pin_sync

// ==== pag_port_a_gpio.sv ====
/*
 * Port A general-purpose I/O: data latch, direction, analog select,
 * peripheral ownership and the Timer0 clock tap, behind a byte-wide
 * register port with read data one cycle after the read strobe.
 * Assumes the pad drives pinIn from the resolved pad level and that
 * the bit 4 pad is wired as open drain.
 */
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns

module pag_port_a_gpio (
   input  wire logic        clk_sys,               // Core clock, 25 MHz.
   input  wire logic        rstn,                  // Async reset, low.
   input  wire logic        ce,                    // Clock enable.
   input  wire logic [7:0]  addr,                  // Register address.
   input  wire logic [7:0]  wrData,                // Write data.
   input  wire logic        wrStb,                 // Write strobe.
   input  wire logic        rdStb,                 // Read strobe.
   output logic      [7:0]  rdData,                // Read data.
   input  wire logic [5:0]  pinIn,                 // Pad input levels.
   output logic      [5:0]  pinOut,                // Pad output value.
   output logic      [5:0]  pinOe,                 // Pad output enable.
   input  wire logic [5:0]  periphOut,             // Peripheral output.
   input  wire logic [5:0]  periphOe,              // Peripheral enable.
   output logic      [5:0]  analogSelect,          // Pins in analog use.
   output logic             timer0ExternalClockIn  // Timer0 clock tap.
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [5:0] portADataLatch;
   logic [5:0] portADirection;
   logic [5:0] analogConfigReg1;
   logic [5:0] periphOwn;
   logic [5:0] next_portADataLatch;
   logic [7:0] next_rdData;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   pag_pin_if pinBus ();

   assign pinBus.pinRaw = pinIn;

   pag_pin_sync u_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .ce      (ce),
      .pins    (pinBus)
   );

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   wire wrData_h   = wrStb & hit(addr, pag_pkg::PAG_OFF_DATA);
   wire wrDir_h    = wrStb & hit(addr, pag_pkg::PAG_OFF_DIR);
   wire wrAnalog_h = wrStb & hit(addr, pag_pkg::PAG_OFF_ANALOG);
   wire wrSet_h    = wrStb & hit(addr, pag_pkg::PAG_OFF_SET);
   wire wrClr_h    = wrStb & hit(addr, pag_pkg::PAG_OFF_CLR);
   wire wrPeriph_h = wrStb & hit(addr, pag_pkg::PAG_OFF_PERIPH);

   // -----------------------------------------------------------------
   // Pin read value
   // -----------------------------------------------------------------
   // Analog pins read as zero so software never sees a half level.
   wire [5:0] readPins = pinBus.pinLevel & ~analogConfigReg1;

   // -----------------------------------------------------------------
   // Read-modify-write of the latch
   // -----------------------------------------------------------------
   // Set and clear start from the sampled pins, not the latch, so a pin
   // held low by the board is stored low; this is the known hazard of
   // read-modify-write on an open-drain or loaded pin.
   wire [5:0] wrBits = wrData[5:0];
   always_comb begin
      next_portADataLatch = portADataLatch;
      if (wrData_h)
         next_portADataLatch = wrBits;
      else if (wrSet_h)
         next_portADataLatch = readPins | wrBits;
      else if (wrClr_h)
         next_portADataLatch = readPins & ~wrBits;
   end

   // -----------------------------------------------------------------
   // Register storage
   // -----------------------------------------------------------------
   // Reset leaves every pin an input and the capable pins analog.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         portADataLatch   <= pag_pkg::PAG_DATA_RST;
         portADirection   <= pag_pkg::PAG_DIR_RST;
         analogConfigReg1 <= pag_pkg::PAG_ANALOG_RST;
         periphOwn        <= pag_pkg::PAG_PERIPH_RST;
      end else if (ce) begin
         portADataLatch <= next_portADataLatch;
         if (wrDir_h)
            portADirection <= wrBits;
         if (wrAnalog_h)
            analogConfigReg1 <= wrBits & pag_pkg::PAG_ANALOG_CAP;
         if (wrPeriph_h)
            periphOwn <= wrBits;
      end
   end

   // -----------------------------------------------------------------
   // Read data path
   // -----------------------------------------------------------------
   // Unmapped addresses read zero; bits 7 and 6 are always zero.
   always_comb begin
      next_rdData = pag_pkg::PAG_RD_ZERO;
      if (rdStb) begin
         case (addr)
            pag_pkg::PAG_OFF_DATA:   next_rdData = {2'b00, readPins};
            pag_pkg::PAG_OFF_DIR:    next_rdData = {2'b00, portADirection};
            pag_pkg::PAG_OFF_ANALOG: next_rdData = {2'b00, analogConfigReg1};
            pag_pkg::PAG_OFF_SET:    next_rdData = {2'b00, portADataLatch};
            pag_pkg::PAG_OFF_CLR:    next_rdData = {2'b00, portADataLatch};
            pag_pkg::PAG_OFF_PERIPH: next_rdData = {2'b00, periphOwn};
            default:                 next_rdData = pag_pkg::PAG_RD_ZERO;
         endcase
      end
   end

   // Data stands only in the cycle after the strobe.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         rdData <= pag_pkg::PAG_RD_ZERO;
      else if (ce)
         rdData <= next_rdData;
   end

   // -----------------------------------------------------------------
   // Pin drivers
   // -----------------------------------------------------------------
   // Analog selection does not gate the driver; only direction and
   // peripheral ownership do.
   genvar gi;
   generate
      for (gi = 0; gi < pag_pkg::PAG_PORT_W; gi++) begin : g_pin
         wire gpioOe = ~portADirection[gi];
         if (gi == pag_pkg::PAG_OD_BIT) begin : g_od
            // Open drain: enable only when driving a zero.
            assign pinOut[gi] = 1'b0;
            assign pinOe[gi]  = periphOwn[gi] ? (periphOe[gi] & ~periphOut[gi])
                                              : (gpioOe & ~portADataLatch[gi]);
         end else begin : g_cmos
            assign pinOut[gi] = periphOwn[gi] ? periphOut[gi]
                                              : portADataLatch[gi];
            assign pinOe[gi]  = periphOwn[gi] ? periphOe[gi] : gpioOe;
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // Side outputs
   // -----------------------------------------------------------------
   // The timer tap follows the pin even while a peripheral owns it; the
   // timer only listens, so it never contends for the pad.
   assign timer0ExternalClockIn = pinBus.pinLevel[pag_pkg::PAG_OD_BIT];
   assign analogSelect          = analogConfigReg1;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence dataReadSeq;
      ce && rdStb && addr == pag_pkg::PAG_OFF_DATA;
   endsequence

   sequence dirReadSeq;
      ce && rdStb && addr == pag_pkg::PAG_OFF_DIR;
   endsequence

   sequence setWriteSeq;
      ce && wrStb && addr == pag_pkg::PAG_OFF_SET;
   endsequence

   sequence clrWriteSeq;
      ce && wrStb && addr == pag_pkg::PAG_OFF_CLR;
   endsequence

   sequence dataWriteSeq;
      ce && wrStb && addr == pag_pkg::PAG_OFF_DATA;
   endsequence

   read_pins_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      dataReadSeq |=> rdData == {2'b00, $past(readPins)})
      else $error("Port data read does not return pin levels.");

   write_latch_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      dataWriteSeq |=> portADataLatch == $past(wrData[5:0]))
      else $error("Port data write did not reach the latch.");

   rmw_set_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      setWriteSeq |=> portADataLatch == ($past(readPins) | $past(wrData[5:0])))
      else $error("Bit set did not start from sampled pins.");

   rmw_clear_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      clrWriteSeq |=> portADataLatch == ($past(readPins) & ~$past(wrData[5:0])))
      else $error("Bit clear did not start from sampled pins.");

   upper_bits_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      (dataReadSeq or dirReadSeq) |=> rdData[7:6] == 2'b00)
      else $error("Unimplemented bits did not read zero.");

   dir_readback_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && wrStb && addr == pag_pkg::PAG_OFF_DIR ##1 dirReadSeq
      |=> rdData == {2'b00, $past(wrData[5:0], 2)})
      else $error("Direction register did not read back.");

   analog_zero_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      dataReadSeq |=> (rdData[5:0] & $past(analogConfigReg1)) == 6'h00)
      else $error("Analog pin read as nonzero.");

   analog_reset_a: assert property (
      @(posedge clk_sys)
      !rstn |=> analogConfigReg1 == pag_pkg::PAG_ANALOG_RST)
      else $error("Analog config not at reset value.");

   analog_only_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      analogSelect[pag_pkg::PAG_OD_BIT] == 1'b0)
      else $error("Bit 4 pin shown as analog.");

   // The tap lags the pin by the two synchroniser edges, both enabled.
   timer_tap_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      rstn && ce ##1 ce |=> timer0ExternalClockIn == $past(pinIn[4], 2))
      else $error("Timer0 clock tap does not follow pin.");

   generate
      for (gi = 0; gi < pag_pkg::PAG_PORT_W; gi++) begin : g_chk
         pin_tristate_a: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            portADirection[gi] && !periphOwn[gi] |-> !pinOe[gi])
            else $error("Input pin is being driven.");

         pin_drive_a: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            !portADirection[gi] && !periphOwn[gi] && gi != pag_pkg::PAG_OD_BIT
            |-> pinOe[gi] && pinOut[gi] == portADataLatch[gi])
            else $error("Output pin does not show the latch.");

         analog_driver_a: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            analogConfigReg1[gi] && !portADirection[gi] && !periphOwn[gi]
            && gi != pag_pkg::PAG_OD_BIT |-> pinOe[gi])
            else $error("Analog select blocked the driver.");

         periph_owner_a: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            periphOwn[gi] && gi != pag_pkg::PAG_OD_BIT
            |-> pinOe[gi] == periphOe[gi] && pinOut[gi] == periphOut[gi])
            else $error("Peripheral does not own its pin.");
      end
   endgenerate

   open_drain_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !pinOut[4] && (pinOe[4] == (!portADirection[4] && !periphOwn[4]
                                  && !portADataLatch[4]) || periphOwn[4]))
      else $error("Open-drain pin drove a one or missed a zero.");

   // -----------------------------------------------------------------
   // Assertions on register writes, the read port and the clock enable
   // -----------------------------------------------------------------
   // These catch a decode slip that read-back checks alone would miss,
   // because a read goes through its own case on addr, not the hit() decode the writes use.
   sequence dirWriteSeq;
      ce && wrStb && addr == pag_pkg::PAG_OFF_DIR;
   endsequence

   sequence analogWriteSeq;
      ce && wrStb && addr == pag_pkg::PAG_OFF_ANALOG;
   endsequence

   sequence periphWriteSeq;
      ce && wrStb && addr == pag_pkg::PAG_OFF_PERIPH;
   endsequence

   dir_write_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      dirWriteSeq |=> portADirection == $past(wrData[5:0]))
      else $error("Direction write did not land.");

   analog_write_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      analogWriteSeq |=> analogConfigReg1 == ($past(wrData[5:0]) & pag_pkg::PAG_ANALOG_CAP))
      else $error("Analog config write did not land.");

   periph_write_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      periphWriteSeq |=> periphOwn == $past(wrData[5:0]))
      else $error("Ownership write did not land.");

   // A latch that moves without a write would upset the open-drain line.
   latch_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !(ce && wrStb) |=> $stable(portADataLatch))
      else $error("Latch changed without a write.");

   // A frozen clock enable keeps every configuration register still.
   ce_freeze_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !ce |=> $stable(portADirection) && $stable(analogConfigReg1) && $stable(periphOwn))
      else $error("State moved while the clock enable was low.");

   // Between reads the port rests at zero, so a stale byte cannot be
   // taken for a fresh answer.
   rd_idle_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && !rdStb |=> rdData == pag_pkg::PAG_RD_ZERO)
      else $error("Read data did not return to zero.");

   unmapped_read_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && rdStb && addr > pag_pkg::PAG_OFF_PERIPH |=> rdData == pag_pkg::PAG_RD_ZERO)
      else $error("Unmapped address did not read zero.");

   latch_readback_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && rdStb && (addr == pag_pkg::PAG_OFF_SET || addr == pag_pkg::PAG_OFF_CLR)
      |=> rdData == {2'b00, $past(portADataLatch)})
      else $error("Latch read-back does not match the latch.");

   dir_read_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      dirReadSeq |=> rdData == {2'b00, $past(portADirection)})
      else $error("Direction read does not show the register.");

   // The synchronised copy lags the pins by exactly two enabled edges.
   sync_delay_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      rstn && ce ##1 ce |=> pinBus.pinLevel == $past(pinIn, 2))
      else $error("Pin synchroniser delay is not two edges.");

endmodule // pag_port_a_gpio

// ==== pag_pin_board.sv ====
/*
 * Board model for the port A pads: resolves each pad from the device
 * driver, the board driver, a pull-up on bit 4 and floating lines.
 * Assumes the bench keeps its board drive off pins the device drives.
 */
`timescale 1ns/1ns

module pag_pin_board (
   input  wire logic       clk_sys,  // Core clock, ages floating pins.
   input  wire logic [5:0] pinOut,   // Device output value.
   input  wire logic [5:0] pinOe,    // Device output enable.
   input  wire logic [5:0] extVal,   // Board drive value.
   input  wire logic [5:0] extEn,    // Board drive enable.
   output logic      [5:0] pinIn     // Resolved pad level.
);
   logic [5:0] lastLvl = 6'h00;

   // ----------------------------------------------------------------
   // Pad resolution
   // ----------------------------------------------------------------
   // Bit 4 only sinks current, so a released bit 4 rises on its pull-up.
   // A pin other than bit 4 that nobody drives flips every cycle so no stale value can pass.
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (pinOe[i]) begin
            pinIn[i] = (i == 4) ? 1'b0 : pinOut[i];
         end else if (extEn[i]) begin
            pinIn[i] = extVal[i];
         end else if (i == 4) begin
            pinIn[i] = 1'b1;
         end else begin
            pinIn[i] = ~lastLvl[i];
         end
      end
   end

   // Remember the last level so a floating pin keeps changing.
   always_ff @(posedge clk_sys) begin
      lastLvl <= pinIn;
   end
endmodule // pag_pin_board

// ==== pag_tb.sv ====
/*
 * Self-checking bench for the port A I/O block with a board model.
 * Assumes the one-cycle register port and two-flop pin sampling.
 */
`timescale 1ns/1ns

module tb;
   logic        clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, wrStb = 1'b0, rdStb = 1'b0, rdPend = 1'b0;
   logic [7:0]  addr = 8'h00, wrData = 8'h00, rdData;
   logic [5:0]  pinIn, pinOut, pinOe, analogSelect, periphOut = 6'h00, periphOe = 6'h00;
   logic [5:0]  extVal = 6'h15, extEn = 6'h3F, dir, lat, lvl;
   logic        timer0ExternalClockIn;
   logic [7:0]  expQ[$];
   logic [31:0] seed = 32'hFACB9664;
   int          num_errors = 0, n_tests = 0;

   pag_port_a_gpio u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wrData(wrData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .periphOut(periphOut), .periphOe(periphOe), .analogSelect(analogSelect),
      .timer0ExternalClockIn(timer0ExternalClockIn));
   pag_pin_board u_board (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
      .extEn(extEn), .pinIn(pinIn));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   always #20 clk_sys = ~clk_sys;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus cycle; a read leaves its expected value in the queue.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      if (!wr) expQ.push_back(e);
      wrStb <= wr;
      rdStb <= !wr;
      addr <= a;
      wrData <= d;
      @(posedge clk_sys);
   endtask

   task automatic idle(input int n);
      wrStb <= 1'b0;
      rdStb <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask

   // Pad outputs are looked at once the edge's register updates landed.
   task automatic pinChk(input logic [5:0] oe, input logic [5:0] out, input logic [5:0] an);
      wrStb <= 1'b0;
      rdStb <= 1'b0;
      #1;
      check({2'b0, pinOe}, {2'b0, oe});
      check({2'b0, pinOut}, {2'b0, out});
      check({2'b0, analogSelect}, {2'b0, an});
      check({7'b0, timer0ExternalClockIn}, {7'b0, pinIn[4]});
      @(posedge clk_sys);
   endtask

   task automatic print_verdict;
      if (expQ.size() != 0) num_errors++;
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Read monitor: read data stand one cycle after the strobe only.
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rdPend) begin
         if (expQ.size() == 0) num_errors++;
         else check(rdData, expQ.pop_front());
      end
      rdPend <= rdStb && ce && rstn;
   end

   // Watchdog, far beyond the few hundred cycles the run needs.
   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      idle(4);
      pinChk(6'h00, 6'h00, 6'h2F);
      bus(0, pag_pkg::PAG_OFF_DIR, 8'h00, 8'h3F);
      bus(0, pag_pkg::PAG_OFF_ANALOG, 8'h00, 8'h2F);
      bus(0, pag_pkg::PAG_OFF_DATA, 8'h00, 8'h10);
      bus(1, pag_pkg::PAG_OFF_ANALOG, 8'hFF, 8'h00);
      bus(0, pag_pkg::PAG_OFF_ANALOG, 8'h00, 8'h2F);
      bus(1, pag_pkg::PAG_OFF_ANALOG, 8'h00, 8'h00);
      // Random direction and latch; the board drives only input pins.
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         dir = seed[5:0];
         lat = seed[13:8];
         bus(1, pag_pkg::PAG_OFF_DIR, seed[7:0], 8'h00);
         extEn <= dir;
         extVal <= seed[21:16];
         bus(1, pag_pkg::PAG_OFF_DATA, seed[15:8], 8'h00);
         lvl = (dir & seed[21:16]) | (~dir & lat);
         idle(4);
         pinChk(~dir & ~(lat & 6'h10), lat & 6'h2F, 6'h00);
         bus(0, pag_pkg::PAG_OFF_DIR, 8'h00, {2'b0, dir});
         bus(0, pag_pkg::PAG_OFF_DATA, 8'h00, {2'b0, lvl});
         seed = lfsr(seed);
         lat = lvl | seed[5:0];
         bus(1, pag_pkg::PAG_OFF_SET, seed[7:0], 8'h00);
         bus(0, pag_pkg::PAG_OFF_SET, 8'h00, {2'b0, lat});
         idle(4);
         lvl = (dir & extVal) | (~dir & lat);
         lat = lvl & ~seed[13:8];
         bus(1, pag_pkg::PAG_OFF_CLR, seed[15:8], 8'h00);
         bus(0, pag_pkg::PAG_OFF_CLR, 8'h00, {2'b0, lat});
      end
      // Unmapped places and a frozen clock enable leave state alone.
      bus(1, 8'h07, 8'hFF, 8'h00);
      bus(0, 8'h06, 8'h00, 8'h00);
      bus(0, pag_pkg::PAG_OFF_DIR, 8'h00, {2'b0, dir});
      ce <= 1'b0;
      bus(1, pag_pkg::PAG_OFF_DIR, {2'b0, ~dir}, 8'h00);
      ce <= 1'b1;
      bus(0, pag_pkg::PAG_OFF_DIR, 8'h00, {2'b0, dir});
      // A sharing peripheral takes pins 0 and 5.
      seed = lfsr(seed);
      periphOe <= seed[5:0];
      periphOut <= seed[13:8];
      bus(1, pag_pkg::PAG_OFF_PERIPH, 8'h21, 8'h00);
      pinChk((~dir & ~(lat & 6'h10) & 6'h1E) | (seed[5:0] & 6'h21),
             (lat & 6'h0E) | (seed[13:8] & 6'h21), 6'h00);
      bus(1, pag_pkg::PAG_OFF_PERIPH, 8'h00, 8'h00);
      // Direction still drives an analog pin: pin 0 is made an output while analog is selected.
      bus(1, pag_pkg::PAG_OFF_DIR, 8'h3F, 8'h00);
      bus(0, pag_pkg::PAG_OFF_DIR, 8'h00, 8'h3F);
      extEn <= 6'h3F;
      extVal <= 6'h3F;
      bus(1, pag_pkg::PAG_OFF_ANALOG, 8'h2F, 8'h00);
      idle(4);
      bus(0, pag_pkg::PAG_OFF_DATA, 8'h00, 8'h10);
      bus(1, pag_pkg::PAG_OFF_DIR, 8'h3E, 8'h00);
      extEn <= 6'h3E;
      pinChk(6'h01, lat & 6'h2F, 6'h2F);
      idle(3);
      print_verdict();
   end
endmodule // tb
